// file: core/bcl_bus_ctrl.sv
// Bus strobes, cycle status, wait states and low-power control of the processor.
`timescale 1ns/10ps
module bcl_bus_ctrl
  import bcl_pkg::*;
#(
  parameter int STANDBY_RECOVERY_CYCLES = SLOW_RECOVERY_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cyc_start,
  input wire logic [3:0] cyc_kind,
  input wire logic [19:0] cyc_addr,
  input wire logic [7:0] cyc_wdata,
  input wire logic cyc_last,
  input wire logic cyc_chan,
  input wire logic instr_end,
  input wire logic halt_instruction,
  input wire logic sleep_instruction,
  input wire logic return_from_irq_instr,
  input wire logic [19:0] return_from_irq_instr_pc,
  input wire logic [19:0] return_from_irq_instr_sp,
  input wire logic irq_enable_flag,
  input wire logic [2:0] irq_mask,
  input wire logic [1:0] lp_mode,
  input wire logic [1:0] clk_ratio,
  input wire logic fetch_marker_enable,
  input wire logic fetch_marker_pulse_wr,
  input wire logic fetch_marker_pulse_wdata,
  input wire logic io_timing_compat_wr,
  input wire logic io_timing_compat_wdata,
  input wire logic lowpower_bus_grant_en,
  input wire logic quick_recovery_select,
  input wire logic timer1_select,
  input wire logic timer1_output,
  input wire logic tx_clock,
  input wire logic tx0_bit,
  input wire logic tx1_bit,
  input wire logic wait_n,
  input wire logic bus_hold_request_n,
  input wire logic nmi_n,
  input wire logic ext_irq0_n,
  input wire logic ext_irq1_n,
  input wire logic ext_irq2_n,
  input wire logic [7:0] data_in,
  output logic cyc_ready,
  output logic cyc_done,
  output logic [7:0] cyc_rdata,
  output logic nmi_take,
  output logic [19:0] nmi_vector,
  output logic wake_service,
  output logic wake_resume,
  output logic fetch_marker_pulse_rd,
  output logic io_timing_compat,
  output logic sys_clock_out,
  output logic [19:0] addr_out,
  output logic addr_oe,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic rd_n,
  output logic wr_n,
  output logic mem_request_n,
  output logic io_request_n,
  output logic refresh_strobe_n,
  output logic fetch_marker_n,
  output logic cycle_status,
  output logic stopped_n,
  output logic xfer_done0_n,
  output logic xfer_done1_n,
  output logic bus_ack_n,
  output logic async_tx0,
  output logic async_tx1
);
  // Pin synchronisers: first stage feeds only the second.
  logic [12:0] sync1_reg;
  logic [12:0] sync2_reg;
  logic wait_s, hold_s, nmi_s;
  logic [2:0] irq_s;
  logic [7:0] din_s;
  // Previous nonmaskable level, for the falling edge.
  logic nmi_prev_reg;
  logic nmi_pend_reg;
  // Bus and power state.
  bcl_tstate_t ts_reg, ts_next;
  bcl_power_t pw_reg;
  logic grant_reg;
  // Current machine cycle.
  bcl_kind_t kind_reg;
  logic [19:0] addr_reg;
  logic [7:0] wdata_reg;
  logic last_reg, chan_reg, force_reg;
  // Return-from-interrupt step counter.
  logic return_from_irq_instr_act_reg;
  logic [3:0] return_from_irq_instr_step_reg;
  // Pending one-shot fetch marker and refresh counter.
  logic marker_pend_reg;
  logic [7:0] refresh_addr_reg;
  // Recovery counter control.
  logic rec_start, rec_abort, rec_busy, rec_done;
  logic [17:0] rec_load;
  logic irq_any, go, tx_prev_reg;
  bcl_kind_t src_kind;
  logic [19:0] src_addr;
  logic clk_stop;
  // Marks the state after T3, when the read data has passed the synchronisers.
  logic cyc_end_reg;

  // Classifiers used by several strobe decodes.
  function automatic logic is_read(input bcl_kind_t k);
    return k inside {K_FETCH1, K_FETCHN, K_MEMRD, K_IORD, K_DMARD};
  endfunction : is_read

  function automatic logic is_io(input bcl_kind_t k);
    return k inside {K_IORD, K_IOWR};
  endfunction : is_io

  function automatic logic is_fetch(input bcl_kind_t k);
    return k inside {K_FETCH1, K_FETCHN};
  endfunction : is_fetch

  // Cycle kind of each step of the return sequence.
  function automatic bcl_kind_t return_from_irq_instr_kind(input logic [3:0] step);
    case (step)
      4'h0, 4'h1: return K_FETCH1;
      4'h5, 4'h7: return K_FETCHN;
      4'h8, 4'h9: return K_MEMRD;
      default: return K_IDLE;
    endcase
  endfunction : return_from_irq_instr_kind

  // Two-flop synchronisers for the data bus, interrupt, nonmaskable and bus hold pins.
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 13'h1FFF;
      sync2_reg <= 13'h1FFF;
    end else begin
      sync1_reg <= {data_in, ext_irq2_n, ext_irq1_n, ext_irq0_n, nmi_n, bus_hold_request_n};
      sync2_reg <= sync1_reg;
    end
  end
  assign {din_s, irq_s, nmi_s, hold_s} = sync2_reg;
  assign wait_s = wait_n;
  assign irq_any = |(irq_mask & ~irq_s);

  // Wait is a pin as well; it gets its own pair of flops.
  logic wait1_reg, wait2_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      wait1_reg <= 1'b1;
      wait2_reg <= 1'b1;
    end else begin
      wait1_reg <= wait_s;
      wait2_reg <= wait1_reg;
    end
  end

  // Next cycle source: the return sequence overrides the core.
  always_comb begin
    src_kind = return_from_irq_instr_act_reg ? return_from_irq_instr_kind(return_from_irq_instr_step_reg) : bcl_kind_t'(cyc_kind);
    case (return_from_irq_instr_step_reg)
      4'h0, 4'h5: src_addr = return_from_irq_instr_pc;
      4'h1, 4'h7: src_addr = return_from_irq_instr_pc + 20'h00001;
      4'h8: src_addr = return_from_irq_instr_sp;
      default: src_addr = return_from_irq_instr_sp + 20'h00001;
    endcase
    if (!return_from_irq_instr_act_reg) begin
      src_addr = cyc_addr;
    end
  end

  // A cycle starts only at cycle end, in run, with no bus hold pending.
  assign go = (ts_reg == TS_IDLE) && (pw_reg == PW_RUN) && !grant_reg && hold_s
              && (cyc_start || return_from_irq_instr_act_reg);

  // T-state sequencing with wait states.
  always_comb begin
    case (ts_reg)
      TS_IDLE: ts_next = go ? ((src_kind == K_IDLE) ? TS_TI : TS_T1) : TS_IDLE;
      TS_T1: ts_next = TS_T2;
      TS_T2, TS_TW: ts_next = wait2_reg ? TS_T3 : TS_TW;
      TS_T3: ts_next = TS_IDLE;
      TS_TI: ts_next = TS_IDLE;
      default: ts_next = TS_IDLE;
    endcase
  end

  // State and cycle capture at the start of a machine cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      ts_reg <= TS_IDLE;
      kind_reg <= K_IDLE;
      addr_reg <= 20'h00000;
      wdata_reg <= 8'h00;
      last_reg <= 1'b0;
      chan_reg <= 1'b0;
      force_reg <= 1'b0;
    end else begin
      ts_reg <= ts_next;
      if (go) begin
        kind_reg <= src_kind;
        addr_reg <= (src_kind == K_REFRESH) ? {src_addr[19:8], refresh_addr_reg} : src_addr;
        wdata_reg <= cyc_wdata;
        last_reg <= cyc_last && !return_from_irq_instr_act_reg;
        chan_reg <= cyc_chan;
        force_reg <= return_from_irq_instr_act_reg && (return_from_irq_instr_step_reg == 4'h5);
      end
    end
  end

  // Return sequence steps advance at each cycle start.
  always_ff @(posedge clock) begin
    if (rst) begin
      return_from_irq_instr_act_reg <= 1'b0;
      return_from_irq_instr_step_reg <= 4'h0;
    end else if (return_from_irq_instr && !return_from_irq_instr_act_reg) begin
      return_from_irq_instr_act_reg <= 1'b1;
      return_from_irq_instr_step_reg <= 4'h0;
    end else if (go && return_from_irq_instr_act_reg) begin
      return_from_irq_instr_act_reg <= (return_from_irq_instr_step_reg != RETURN_FROM_IRQ_INSTR_LAST_STEP);
      return_from_irq_instr_step_reg <= return_from_irq_instr_step_reg + 4'h1;
    end
  end

  // Bus pins, registered from the next T-state.
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      mem_request_n <= 1'b1;
      io_request_n <= 1'b1;
      refresh_strobe_n <= 1'b1;
      xfer_done0_n <= 1'b1;
      xfer_done1_n <= 1'b1;
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      logic act, late;
      bcl_kind_t k;
      k = go ? src_kind : kind_reg;
      act = ts_next inside {TS_T1, TS_T2, TS_TW, TS_T3};
      late = ts_next inside {TS_T2, TS_TW, TS_T3};
      // Legacy timing holds I/O strobes back to T2.
      rd_n <= !(is_read(k) && (is_io(k) && io_timing_compat ? late : act));
      io_request_n <= !(is_io(k) && (io_timing_compat ? late : act));
      mem_request_n <= !(act && !is_io(k) && k != K_IDLE);
      refresh_strobe_n <= !(act && k == K_REFRESH);
      // Data is driven from T1; the strobe waits a state so it never precedes valid data.
      data_oe <= act && k inside {K_MEMWR, K_IOWR, K_DMAWR} && !grant_reg;
      data_out <= go ? cyc_wdata : wdata_reg;
      wr_n <= !(k inside {K_MEMWR, K_IOWR, K_DMAWR} && ts_next inside {TS_T2, TS_TW});
      xfer_done0_n <= !(act && k == K_DMAWR && (go ? cyc_last : last_reg) && !(go ? cyc_chan : chan_reg));
      xfer_done1_n <= !(act && k == K_DMAWR && (go ? cyc_last : last_reg) && (go ? cyc_chan : chan_reg));
    end
  end

  // Address pins; bit 18 may carry the timer output instead.
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_out <= 20'h00000;
      addr_oe <= 1'b0;
    end else begin
      addr_out <= go ? ((src_kind == K_REFRESH) ? {src_addr[19:8], refresh_addr_reg} : src_addr) : addr_reg;
      if (timer1_select) begin
        addr_out[18] <= timer1_output;
      end
      addr_oe <= !grant_reg && !(ts_next == TS_TI);
    end
  end

  // Status trio: latched when a cycle starts or the power state changes, driven high again while the bus stays idle.
  always_ff @(posedge clock) begin
    if (rst) begin
      cycle_status <= 1'b1;
      fetch_marker_n <= 1'b1;
    end else if (pw_reg == PW_HALT) begin
      cycle_status <= 1'b0;
      fetch_marker_n <= 1'b0;
    end else if (pw_reg != PW_RUN) begin
      cycle_status <= 1'b1;
      fetch_marker_n <= 1'b1;
    end else if (go) begin
      cycle_status <= !(src_kind == K_FETCH1 || src_kind inside {K_DMARD, K_DMAWR});
      fetch_marker_n <= !(is_fetch(src_kind) && (fetch_marker_enable || marker_pend_reg
                        || (return_from_irq_instr_act_reg && return_from_irq_instr_step_reg == 4'h5)));
    end else if (ts_reg == TS_IDLE && ts_next == TS_IDLE) begin
      cycle_status <= 1'b1;
      fetch_marker_n <= 1'b1;
    end
  end

  // Stopped indicator follows halt and sleep.
  always_ff @(posedge clock) begin
    if (rst) begin
      stopped_n <= 1'b1;
    end else begin
      stopped_n <= (pw_reg == PW_RUN);
    end
  end

  // Setting registers; a write of zero arms a single forced marker, and the arm beats the clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      marker_pend_reg <= 1'b0;
      fetch_marker_pulse_rd <= FETCH_PULSE_RST;
      io_timing_compat <= IO_COMPAT_RST;
    end else begin
      fetch_marker_pulse_rd <= FETCH_PULSE_RST;
      if (io_timing_compat_wr) begin
        io_timing_compat <= io_timing_compat_wdata;
      end
      if (fetch_marker_pulse_wr && !fetch_marker_pulse_wdata) begin
        marker_pend_reg <= 1'b1;
      end else if (go && is_fetch(src_kind)) begin
        marker_pend_reg <= 1'b0;
      end
    end
  end

  // Refresh counter steps once per refresh cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      refresh_addr_reg <= REFRESH_ADDR_RST;
    end else if (go && src_kind == K_REFRESH) begin
      refresh_addr_reg <= refresh_addr_reg + 8'h01;
    end
  end

  // Cycle completion and read data, one state after T3: the synchronised data bus lags the pins
  // by two clocks, and a legacy I/O read only gates its data from T2.
  always_ff @(posedge clock) begin
    if (rst) begin
      cyc_end_reg <= 1'b0;
      cyc_done <= 1'b0;
      cyc_rdata <= 8'h00;
      cyc_ready <= 1'b0;
    end else begin
      cyc_end_reg <= (ts_next == TS_IDLE) && (ts_reg inside {TS_T3, TS_TI});
      cyc_done <= cyc_end_reg;
      if (cyc_end_reg) begin
        cyc_rdata <= din_s;
      end
      cyc_ready <= (ts_next == TS_IDLE) && (pw_reg == PW_RUN) && !grant_reg && !return_from_irq_instr_act_reg;
    end
  end

  // Nonmaskable edge latch; a new edge beats the clear.
  always_ff @(posedge clock) begin
    if (rst) begin
      nmi_prev_reg <= 1'b1;
      nmi_pend_reg <= 1'b0;
      nmi_take <= 1'b0;
      nmi_vector <= NMI_VECTOR;
    end else begin
      nmi_prev_reg <= nmi_s;
      nmi_vector <= NMI_VECTOR;
      nmi_take <= nmi_pend_reg && instr_end && pw_reg == PW_RUN && hold_s && !grant_reg;
      if (nmi_prev_reg && !nmi_s) begin
        nmi_pend_reg <= 1'b1;
      end else if (nmi_take || wake_service) begin
        nmi_pend_reg <= 1'b0;
      end
    end
  end

  // Recovery delays: idle grants wait the extra cycles; standby waits the chosen recovery.
  assign rec_load = (lp_mode == LP_STANDBY)
                    ? (quick_recovery_select ? QUICK_RECOVERY_CYC : 18'(STANDBY_RECOVERY_CYCLES))
                    : IDLE_GRANT_EXTRA_CYC;
  assign rec_start = pw_reg == PW_SLEEP && !grant_reg && !rec_busy && (
                     (lp_mode == LP_STANDBY && (irq_any || nmi_pend_reg))
                     || (lp_mode != LP_SLEEP && lowpower_bus_grant_en && !hold_s));
  assign rec_abort = (pw_reg == PW_WAKE && !irq_any && !nmi_pend_reg)
                     || (pw_reg == PW_GRANT && hold_s);

  // Power state machine.
  always_ff @(posedge clock) begin
    if (rst) begin
      pw_reg <= PW_RUN;
      grant_reg <= 1'b0;
      wake_service <= 1'b0;
      wake_resume <= 1'b0;
      bus_ack_n <= 1'b1;
    end else begin
      wake_service <= 1'b0;
      wake_resume <= 1'b0;
      bus_ack_n <= !grant_reg;
      case (pw_reg)
        PW_RUN: begin
          if (ts_reg == TS_IDLE && !go && !hold_s) begin
            grant_reg <= 1'b1;
          end else if (hold_s) begin
            grant_reg <= 1'b0;
          end
          if (!grant_reg && halt_instruction) begin
            pw_reg <= PW_HALT;
          end else if (!grant_reg && sleep_instruction) begin
            pw_reg <= PW_SLEEP;
          end
        end
        PW_HALT: begin
          if (nmi_pend_reg || irq_any) begin
            pw_reg <= PW_RUN;
          end
        end
        PW_SLEEP: begin
          if (grant_reg && hold_s) begin
            grant_reg <= 1'b0;
          end else if (rec_start) begin
            pw_reg <= (lp_mode == LP_STANDBY && (irq_any || nmi_pend_reg)) ? PW_WAKE : PW_GRANT;
          end else if (lp_mode != LP_STANDBY && !grant_reg && (irq_any || nmi_pend_reg)) begin
            pw_reg <= PW_RUN;
            wake_service <= nmi_pend_reg || irq_enable_flag;
            wake_resume <= !(nmi_pend_reg || irq_enable_flag);
          end
        end
        PW_WAKE: begin
          if (rec_abort) begin
            pw_reg <= PW_SLEEP;
          end else if (rec_done) begin
            pw_reg <= PW_RUN;
            wake_service <= nmi_pend_reg || irq_enable_flag;
            wake_resume <= !(nmi_pend_reg || irq_enable_flag);
          end
        end
        PW_GRANT: begin
          if (rec_abort) begin
            pw_reg <= PW_SLEEP;
          end else if (rec_done) begin
            grant_reg <= 1'b1;
            pw_reg <= PW_SLEEP;
          end
        end
        default: pw_reg <= PW_RUN;
      endcase
    end
  end

  // Clock output stops in idle and standby unless the bus is lent out.
  assign clk_stop = (pw_reg inside {PW_SLEEP, PW_WAKE, PW_GRANT}) && lp_mode != LP_SLEEP && !grant_reg;

  bcl_recovery u_recovery (
    .clock(clock),
    .rst(rst),
    .start(rec_start),
    .abort(rec_abort),
    .load(rec_load),
    .busy(rec_busy),
    .done(rec_done)
  );

  bcl_clkout u_clkout (
    .clock(clock),
    .rst(rst),
    .ratio_sel(clk_ratio),
    .stop(clk_stop),
    .sys_clock_out(sys_clock_out)
  );

  // Transmit bits move only on the falling edge of the transmit clock.
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_prev_reg <= 1'b0;
      async_tx0 <= 1'b1;
      async_tx1 <= 1'b1;
    end else begin
      tx_prev_reg <= tx_clock;
      if (tx_prev_reg && !tx_clock) begin
        async_tx0 <= tx0_bit;
        async_tx1 <= tx1_bit;
      end
    end
  end
endmodule : bcl_bus_ctrl

// file: core/bcl_pkg.sv
// Shared constants and types for the bus cycle, status and low-power block.
package bcl_pkg;
  // Fixed restart address taken on a nonmaskable interrupt.
  localparam logic [19:0] NMI_VECTOR = 20'h00066;
  // Opcode bytes of the return-from-interrupt instruction.
  localparam logic [7:0] RETURN_FROM_IRQ_INSTR_OP1 = 8'hED;
  localparam logic [7:0] RETURN_FROM_IRQ_INSTR_OP2 = 8'h4D;
  // Clock rate of the block, used for documentation of counts only.
  localparam int CLK_MHZ = 25;
  // Extra cycles for a bus grant while in idle mode.
  localparam logic [17:0] IDLE_GRANT_EXTRA_CYC = 18'h00008;
  // Standby restart and grant delays in clocks.
  localparam logic [17:0] QUICK_RECOVERY_CYC = 18'h00040;
  localparam int SLOW_RECOVERY_CYC = 131072;
  // Number of the last step of the return-from-interrupt sequence.
  localparam logic [3:0] RETURN_FROM_IRQ_INSTR_LAST_STEP = 4'h9;
  // Values after reset.
  localparam logic FETCH_PULSE_RST = 1'b1;
  localparam logic IO_COMPAT_RST = 1'b1;
  localparam logic [7:0] REFRESH_ADDR_RST = 8'h00;
  // Low-power mode selections.
  localparam logic [1:0] LP_SLEEP = 2'h0;
  localparam logic [1:0] LP_IDLE = 2'h1;
  localparam logic [1:0] LP_STANDBY = 2'h2;
  // Clock output ratio selections, relative to the crystal reference.
  localparam logic [1:0] RATIO_HALF = 2'h0;
  localparam logic [1:0] RATIO_ONE = 2'h1;
  localparam logic [1:0] RATIO_TWO = 2'h2;

  // Kinds of machine cycle.
  typedef enum logic [3:0] {
    K_FETCH1 = 4'h0, K_FETCHN = 4'h1, K_MEMRD = 4'h2, K_MEMWR = 4'h3,
    K_IORD = 4'h4, K_IOWR = 4'h5, K_REFRESH = 4'h6, K_DMARD = 4'h7,
    K_DMAWR = 4'h8, K_IDLE = 4'h9
  } bcl_kind_t;

  // Bus T-states, one-hot.
  typedef enum logic [5:0] {
    TS_IDLE = 6'b000001, TS_T1 = 6'b000010, TS_T2 = 6'b000100,
    TS_TW = 6'b001000, TS_T3 = 6'b010000, TS_TI = 6'b100000
  } bcl_tstate_t;

  // Power states, one-hot.
  typedef enum logic [4:0] {
    PW_RUN = 5'b00001, PW_HALT = 5'b00010, PW_SLEEP = 5'b00100,
    PW_WAKE = 5'b01000, PW_GRANT = 5'b10000
  } bcl_power_t;
endpackage : bcl_pkg

// file: core/bcl_clkout.sv
// System clock output divider with ratio select and stop control.
`timescale 1ns/10ps
module bcl_clkout
  import bcl_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] ratio_sel,
  input wire logic stop,
  output logic sys_clock_out
);
  // Free-running prescaler; its two low bits give the two slower ratios.
  logic [2:0] div_reg;
  // Selected toggle point of the prescaler.
  logic tick;

  // The clock input stands in for four times the crystal rate, so the fastest ratio toggles every cycle.
  always_comb begin
    case (ratio_sel)
      RATIO_TWO: tick = 1'b1;
      RATIO_ONE: tick = div_reg[0];
      default: tick = div_reg[1] & div_reg[0];
    endcase
  end

  // Prescaler counts every cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  // Stopping parks the output low, so restarting never makes a short pulse.
  always_ff @(posedge clock) begin
    if (rst || stop) begin
      sys_clock_out <= 1'b0;
    end else if (tick) begin
      sys_clock_out <= ~sys_clock_out;
    end
  end
endmodule : bcl_clkout

// file: core/bcl_recovery.sv
// Countdown timer for standby restart and low-power bus grant delays.
`timescale 1ns/10ps
module bcl_recovery
  import bcl_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [17:0] load,
  output logic busy,
  output logic done
);
  // Remaining cycles of the current delay.
  logic [17:0] count_reg;

  // A start loads the count; abort drops it without a done pulse.
  always_ff @(posedge clock) begin
    if (rst || abort) begin
      count_reg <= 18'h00000;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      count_reg <= load;
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy) begin
      count_reg <= count_reg - 18'h00001;
      busy <= (count_reg > 18'h00001);
      done <= (count_reg <= 18'h00001);
    end else begin
      done <= 1'b0;
    end
  end
endmodule : bcl_recovery

// file: tb/bcl_bus_ctrl_properties.sv
// Checker of strobes, status codes and hold outputs of the bus controller.
`timescale 1ns/10ps
module bcl_bus_ctrl_properties (
  input wire logic clock, input wire logic rst, input wire logic nmi_take, input wire logic [19:0] nmi_vector,
  input wire logic fetch_marker_pulse_rd, input wire logic addr_oe, input wire logic data_oe,
  input wire logic rd_n, input wire logic wr_n, input wire logic mem_request_n, input wire logic io_request_n,
  input wire logic refresh_strobe_n, input wire logic fetch_marker_n, input wire logic cycle_status,
  input wire logic stopped_n, input wire logic xfer_done0_n, input wire logic xfer_done1_n,
  input wire logic bus_ack_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // A strobe only means something when a request qualifies it.
  sequence req_s; !mem_request_n || !io_request_n; endsequence
  refresh_pair_a:
    assert property (!refresh_strobe_n |-> !mem_request_n) else $error("refresh without memory request");
  read_req_a:
    assert property (!rd_n |-> req_s) else $error("read strobe without request");
  read_float_a:
    assert property (!rd_n |-> !data_oe) else $error("data driven during read");
  write_data_a:
    assert property (!wr_n |-> (data_oe and req_s)) else $error("write strobe without data");
  nmi_vector_a:
    assert property (nmi_take |-> nmi_vector == 20'h00066) else $error("bad restart address");
  marker_read_a:
    assert property (fetch_marker_pulse_rd == 1'b1) else $error("marker bit reads zero");
  hold_float_a:
    assert property (!bus_ack_n |-> !addr_oe && !data_oe) else $error("bus driven while granted");
  xfer_end_a:
    assert property (!xfer_done0_n |-> xfer_done1_n && rd_n) else $error("bad transfer end");
  stop_code_a:
    assert property (!stopped_n |-> fetch_marker_n == cycle_status) else $error("bad stopped status code");
endmodule : bcl_bus_ctrl_properties
bind bcl_bus_ctrl bcl_bus_ctrl_properties chk (.*);

// file: tb/bcl_far_model.sv
// Far-side memory and I/O model that answers reads and stretches cycles.
`timescale 1ns/10ps
module bcl_far_model (
  input wire logic clock,
  input wire logic rd_n,
  input wire logic [19:0] addr_out,
  input wire logic [3:0] waits,
  output logic [7:0] data_in,
  output logic wait_n
);
  logic [3:0] cnt_reg = 4'h0; // Cycles since the read strobe fell.
  logic [7:0] junk_reg = 8'h00; // Changes every cycle so a released bus never looks valid.
  // Count strobe cycles and let the idle bus drift.
  always @(posedge clock) begin
    cnt_reg <= rd_n ? 4'h0 : cnt_reg + 4'h1;
    junk_reg <= ~junk_reg + 8'h3;
  end
  assign data_in = !rd_n ? addr_out[7:0] ^ 8'h5A : junk_reg;
  assign wait_n = rd_n || cnt_reg >= waits;
endmodule : bcl_far_model

// file: tb/tb_top.sv
// Random and corner-case testbench for the bus controller.
`timescale 1ns/10ps
module tb_top;
  import bcl_pkg::*;
  logic clock, rst, cyc_start, cyc_last, cyc_chan, instr_end, halt_instruction, sleep_instruction;
  logic return_from_irq_instr, irq_enable_flag, fetch_marker_enable, fetch_marker_pulse_wr, fetch_marker_pulse_wdata;
  logic io_timing_compat_wr, io_timing_compat_wdata, lowpower_bus_grant_en, quick_recovery_select, timer1_select;
  logic timer1_output, tx_clock, tx0_bit, tx1_bit, wait_n, bus_hold_request_n, nmi_n, ext_irq0_n, ext_irq1_n, ext_irq2_n;
  logic [3:0] cyc_kind, waits, k;
  logic [19:0] cyc_addr, return_from_irq_instr_pc, return_from_irq_instr_sp, addr_out, nmi_vector, a;
  logic [7:0] cyc_wdata, data_in, cyc_rdata, data_out, rcnt;
  logic [13:0] snap;
  logic [2:0] irq_mask;
  logic [1:0] lp_mode, clk_ratio;
  logic cyc_ready, cyc_done, nmi_take, wake_service, wake_resume, fetch_marker_pulse_rd, io_timing_compat;
  logic sys_clock_out, addr_oe, data_oe, rd_n, wr_n, mem_request_n, io_request_n, refresh_strobe_n, fetch_marker_n;
  logic cycle_status, stopped_n, xfer_done0_n, xfer_done1_n, bus_ack_n, async_tx0, async_tx1;
  int error_cnt, tests_run, n;
  bcl_bus_ctrl #(.STANDBY_RECOVERY_CYCLES(100)) DUT (.*);
  bcl_far_model far (.clock(clock), .rd_n(rd_n), .addr_out(addr_out), .waits(waits), .data_in(data_in),
    .wait_n(wait_n));
  // Free-running 25 MHz clock.
  always #20 clock = ~clock;
  // Compare a seen value with an expected one and count both outcomes.
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (error_cnt == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  // Transfer ends, strobe, status and low address byte expected in T1; cl is channel then last.
  function automatic logic [13:0] t1_code(input logic [3:0] kd, input logic [19:0] ad, input logic [1:0] cl);
    return {!(kd == K_DMAWR && cl == 2'b11), !(kd == K_DMAWR && cl == 2'b01), kd != K_REFRESH,
            kd == K_FETCH1 ? 3'b010 : kd == K_FETCHN ? 3'b110 : kd inside {K_DMARD, K_DMAWR} ? 3'b011 : 3'b111,
            ad[7:0]};
  endfunction : t1_code
  // Wait a bounded number of cycles for a flag; n gives the count.
  task automatic wait_on(ref logic f, input int lim);
    n = 0;
    while (f !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_on
  // One machine cycle with a snapshot taken in T1.
  task automatic run(input logic [3:0] kd, input logic [19:0] ad);
    wait_on(cyc_ready, 50);
    {cyc_kind, cyc_addr, cyc_wdata, cyc_start} = {kd, ad, ad[7:0], 1'b1};
    @(negedge clock);
    cyc_start = 1'b0;
    snap = {xfer_done1_n, xfer_done0_n, refresh_strobe_n, cycle_status, stopped_n, fetch_marker_n, addr_out[7:0]};
    wait_on(cyc_done, 50);
  endtask : run
  initial begin
    {clock, cyc_start, cyc_last, cyc_chan, instr_end, halt_instruction, sleep_instruction, return_from_irq_instr} = '0;
    {irq_enable_flag, fetch_marker_pulse_wr, fetch_marker_pulse_wdata, io_timing_compat_wr, timer1_select} = '0;
    {lowpower_bus_grant_en, quick_recovery_select, io_timing_compat_wdata, timer1_output, tx_clock, tx0_bit} = '0;
    {tx1_bit, irq_mask, lp_mode, clk_ratio, return_from_irq_instr_pc, return_from_irq_instr_sp, waits} = '0;
    {rst, fetch_marker_enable, bus_hold_request_n, nmi_n, ext_irq0_n, ext_irq1_n, ext_irq2_n} = '1;
    void'($urandom(15098));
    rcnt = REFRESH_ADDR_RST;
    repeat (4) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    check({io_timing_compat, stopped_n, cycle_status}, 3'b111);
    for (int i = 0; i < 60; i++) begin
      k = i < 9 ? i : $urandom_range(8, 0);
      a = $urandom;
      waits = $urandom_range(3, 0);
      {cyc_last, cyc_chan} = 2'($urandom);
      if (i == 30) begin
        {io_timing_compat_wr, io_timing_compat_wdata} = 2'b10;
        @(negedge clock);
        io_timing_compat_wr = 1'b0;
        check(io_timing_compat, 1'b0);
      end
      run(k, a);
      check(snap, t1_code(k, k == K_REFRESH ? {12'h000, rcnt} : a, {cyc_chan, cyc_last}));
      if (k == K_REFRESH) rcnt++;
      if (k inside {K_FETCH1, K_FETCHN, K_MEMRD, K_IORD, K_DMARD}) check(cyc_rdata, a[7:0] ^ 8'h5A);
    end
    bus_hold_request_n = 1'b0;
    repeat (5) @(negedge clock);
    check({bus_ack_n, addr_oe, cyc_ready}, 3'b000);
    bus_hold_request_n = 1'b1;
    repeat (5) @(negedge clock);
    check({bus_ack_n, addr_oe}, 2'b11);
    {fetch_marker_enable, fetch_marker_pulse_wr} = 2'b01;
    @(negedge clock);
    fetch_marker_pulse_wr = 1'b0;
    run(K_FETCHN, 20'h00123);
    check(snap[8], 1'b0);
    run(K_FETCHN, 20'h00124);
    check(snap[8], 1'b1);
    nmi_n = 1'b0;
    repeat (6) @(negedge clock);
    check(nmi_take, 1'b0);
    instr_end = 1'b1;
    @(negedge clock);
    instr_end = 1'b0;
    wait_on(nmi_take, 4);
    check(n < 4, 1'b1);
    {lp_mode, irq_mask, irq_enable_flag, quick_recovery_select, sleep_instruction} = {LP_STANDBY, 3'b001, 3'b011};
    @(negedge clock);
    sleep_instruction = 1'b0;
    repeat (4) @(negedge clock);
    check({stopped_n, cycle_status, fetch_marker_n}, 3'b011);
    ext_irq0_n = 1'b0;
    wait_on(wake_resume, 200);
    check(n >= 64 && n < 80, 1'b1);
    results();
  end
  // Cut a hang short well after the expected run time.
  initial begin
    #200000;
    error_cnt++;
    results();
  end
endmodule : tb_top
